// *** core/amrf_pkg.sv ***
package amrf_pkg;

  // ****************************************************************
  // register indices, byte address is four times the index
  // ****************************************************************
  localparam logic [9:0] IDX_RESULT_LOW   = 10'h078;
  localparam logic [9:0] IDX_RESULT_HIGH  = 10'h079;
  localparam logic [9:0] IDX_INPUT_SELECT = 10'h07C;
  localparam logic [9:0] IDX_IRQ_STATUS   = 10'h080;
  localparam logic [9:0] IDX_IRQ_MASK     = 10'h081;
  localparam logic [9:0] IDX_CONV_STATUS  = 10'h082;
  localparam int         ADDR_WIDTH       = 12;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int         SEL_REF_MSB      = 7;
  localparam int         SEL_REF_LSB      = 6;
  localparam int         SEL_LEFT_ADJUST  = 5;
  localparam int         SEL_CHAN_MSB     = 4;
  localparam int         SEL_CHAN_LSB     = 0;
  localparam int         STAT_DONE        = 0;
  localparam int         CSTAT_BUSY       = 0;
  localparam int         CSTAT_LOCKED     = 1;
  localparam logic [7:0] RST_INPUT_SELECT = 8'h00;
  localparam logic [0:0] RST_IRQ_MASK     = 1'h0;
  localparam logic [9:0] RST_RESULT       = 10'h000;

  // ****************************************************************
  // channel code boundaries
  // ****************************************************************
  localparam logic [4:0] CH_SINGLE_LAST   = 5'h07;
  localparam logic [4:0] CH_GAIN_LAST     = 5'h0F;
  localparam logic [4:0] CH_NEG1_LAST     = 5'h17;
  localparam logic [4:0] CH_NEG2_LAST     = 5'h1D;
  localparam logic [4:0] CH_BANDGAP       = 5'h1E;
  localparam logic [4:0] CH_GROUND        = 5'h1F;

  // ****************************************************************
  // axi responses
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;

  typedef enum logic [1:0] {
    REF_EXTERNAL_PIN = 2'b00,
    REF_ANALOG_SUPPLY = 2'b01,
    REF_INTERNAL_1V1 = 2'b10,
    REF_INTERNAL_2V56 = 2'b11
  } amrf_ref_type;

  typedef enum logic [1:0] {
    GAIN_1X   = 2'b00,
    GAIN_10X  = 2'b01,
    GAIN_200X = 2'b10
  } amrf_gain_type;

  typedef enum logic [0:0] {
    CONV_IDLE = 1'b0,
    CONV_BUSY = 1'b1
  } amrf_conv_state_type;

  typedef struct packed {
    logic          differential;
    logic          bandgap;
    logic          ground;
    logic [2:0]    positive;
    logic [2:0]    negative;
    amrf_gain_type gain;
  } amrf_chan_type;

  typedef struct packed {
    amrf_ref_type  reference;
    amrf_chan_type channel;
  } amrf_select_type;

endpackage : amrf_pkg

// *** core/amrf_top.sv ***
`timescale 1ns/10ps
`default_nettype none

// Contract
// RQ1 - single-ended result is unsigned ten-bit code
// RQ2 - differential result is two's complement code
// RQ3 - bit nine of differential result is sign
// RQ4 - result registers valid when done flag high
// RQ5 - two-bit field picks converter reference
// RQ6 - selection writes wait until conversion completes
// RQ7 - adjust bit selects left or right presentation
// RQ8 - adjust change reformats stored result immediately
// RQ9 - codes zero-seven single inputs, bandgap, ground
// RQ10 - remaining codes select differential pairs and gains
// RQ11 - software uses 2.56V reference with gain
// RQ12 - byte layout for left and right adjust
// RQ13 - low read blocks updates until high read
// RQ14 - done flag set when result registers update; code also sets it on a completion that the low-read lock discards
// RQ15 - selection captured into working copy at start
module amrf_top
  import amrf_pkg::*;
#(
  parameter int RESULT_WIDTH = 10
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic [ADDR_WIDTH-1:0]   s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [ADDR_WIDTH-1:0]   s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire logic                    conv_start,
  input  wire logic                    core_done,
  input  wire logic [RESULT_WIDTH-1:0] core_code,
  output amrf_select_type              work_select,
  output logic                         conv_busy,
  output logic                         irq
);

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (RESULT_WIDTH != 10) begin : g_width_check
    $error("amrf_top serves a ten-bit result only");
  end
  if (ADDR_WIDTH != 12) begin : g_addr_check
    $error("amrf_top decodes a twelve-bit byte address only");
  end

  // ****************************************************************
  // helper functions
  // ****************************************************************
  function automatic amrf_chan_type decode_channel(input logic [4:0] code);
    amrf_chan_type c;
    c = '0;
    if (code <= CH_SINGLE_LAST) begin
      c.positive = code[2:0];
    end else if (code <= CH_GAIN_LAST) begin
      // bit 2 picks the pair, bit 1 the gain
      c.differential = 1'b1;
      c.negative     = {1'b0, code[2], 1'b0};
      c.positive     = {1'b0, code[2], code[0]};
      c.gain         = code[1] ? GAIN_200X : GAIN_10X;
    end else if (code <= CH_NEG1_LAST) begin
      c.differential = 1'b1;
      c.negative     = 3'h1;
      c.positive     = code[2:0];
    end else if (code <= CH_NEG2_LAST) begin
      c.differential = 1'b1;
      c.negative     = 3'h2;
      c.positive     = code[2:0];
    end else if (code == CH_BANDGAP) begin
      c.bandgap = 1'b1;
    end else begin
      c.ground = 1'b1;
    end
    return c;
  endfunction : decode_channel

  function automatic logic [7:0] result_byte(input logic [9:0] r, input logic left,
                                             input logic high);
    logic [15:0] word;
    word = left ? {r, 6'h00} : {6'h00, r};
    return high ? word[15:8] : word[7:0];
  endfunction : result_byte

  function automatic logic [9:0] word_index(input logic [ADDR_WIDTH-1:0] a);
    return a[ADDR_WIDTH-1:2];
  endfunction : word_index

  function automatic logic is_mapped(input logic [9:0] idx);
    case (idx)
      IDX_INPUT_SELECT, IDX_IRQ_STATUS, IDX_IRQ_MASK,
      IDX_RESULT_LOW, IDX_RESULT_HIGH, IDX_CONV_STATUS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : is_mapped

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]          input_select_q;
  logic [9:0]          result_q;
  logic                locked_q;
  logic                done_flag_q;
  logic                irq_mask_q;
  amrf_conv_state_type state_q;
  amrf_select_type     work_q;
  logic                sel_we;
  logic                mask_we;
  logic                status_we;
  logic                low_read;
  logic                high_read;
  logic                aw_held_q;
  logic                w_held_q;
  logic [9:0]          aw_index_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [1:0]          rresp_q;
  logic [31:0]         rdata_q;
  logic                wr_fire;
  logic                rd_fire;
  logic [9:0]          rd_index;
  amrf_select_type     sel_live;
  logic                finish;
  logic [9:0]          coded;
  logic                done_clear;

  // ****************************************************************
  // axi write channels
  // ****************************************************************
  // a taken channel waits for its partner; a pending response blocks both
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign wr_fire       = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_q  <= 1'b0;
      aw_index_q <= 10'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_q  <= 1'b1;
      aw_index_q <= word_index(s_axi_awaddr);
    end else if (wr_fire) begin
      aw_held_q  <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= is_mapped(aw_index_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  // lane zero carries every field of these byte-wide registers
  assign sel_we    = wr_fire && aw_index_q == IDX_INPUT_SELECT && wstrb_q[0];
  assign mask_we   = wr_fire && aw_index_q == IDX_IRQ_MASK && wstrb_q[0];
  assign status_we = wr_fire && aw_index_q == IDX_IRQ_STATUS && wstrb_q[0];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      input_select_q <= RST_INPUT_SELECT;
    end else if (sel_we) begin
      input_select_q <= wdata_q[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_q <= RST_IRQ_MASK;
    end else if (mask_we) begin
      irq_mask_q <= wdata_q[STAT_DONE];
    end
  end

  assign done_clear = status_we && wdata_q[STAT_DONE];

  // ****************************************************************
  // selection decode and working copy
  // ****************************************************************
  assign sel_live.reference = amrf_ref_type'(input_select_q[SEL_REF_MSB:SEL_REF_LSB]); // [RQ5]
  assign sel_live.channel   =
    decode_channel(input_select_q[SEL_CHAN_MSB:SEL_CHAN_LSB]); // [RQ9] [RQ10]

  assign finish = (state_q == CONV_BUSY) && core_done;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CONV_IDLE;
    end else begin
      case (state_q)
        CONV_IDLE: begin
          if (conv_start) begin
            state_q <= CONV_BUSY;
          end
        end
        CONV_BUSY: begin
          if (core_done) begin
            state_q <= CONV_IDLE;
          end
        end
        default: state_q <= CONV_IDLE;
      endcase
    end
  end

  // idle: follow register; busy: frozen until completion
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      work_q <= '0;
    end else if (state_q == CONV_IDLE) begin
      work_q <= sel_live; // [RQ15] [RQ6]
    end
  end

  // driven from the flops so the far side never sees a decode glitch
  assign work_select = work_q; // [RQ6] [RQ15]
  assign conv_busy   = (state_q == CONV_BUSY);

  // ****************************************************************
  // result capture and done flag
  // ****************************************************************
  // core gives offset binary for differential; flip msb to two's complement
  assign coded = work_q.channel.differential
                 ? {~core_code[9], core_code[8:0]} // [RQ2] [RQ3]
                 : core_code; // [RQ1]

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      result_q <= RST_RESULT;
    end else if (finish && (!locked_q || high_read) && !low_read) begin
      // a low read on this edge keeps the old pair together
      result_q <= coded; // [RQ4] [RQ13]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      done_flag_q <= 1'b0;
    end else if (finish) begin
      // completion wins over a clear on the same edge
      done_flag_q <= 1'b1; // [RQ14]
    end else if (done_clear) begin
      done_flag_q <= 1'b0;
    end
  end

  // level output, drops once the flag is cleared or masked
  assign irq = done_flag_q && irq_mask_q;

  // ****************************************************************
  // axi read channel
  // ****************************************************************
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign rd_fire       = s_axi_arvalid && !rvalid_q;
  assign rd_index      = word_index(s_axi_araddr);
  assign low_read      = rd_fire && rd_index == IDX_RESULT_LOW;
  assign high_read     = rd_fire && rd_index == IDX_RESULT_HIGH;

  // lock and read data both act on the accepting edge
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      locked_q <= 1'b0;
    end else if (high_read) begin
      locked_q <= 1'b0; // [RQ13]
    end else if (low_read) begin
      locked_q <= 1'b1; // [RQ13]
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= is_mapped(rd_index) ? RESP_OKAY : RESP_SLVERR;
      rdata_q  <= 32'h0000_0000;
      case (rd_index)
        IDX_INPUT_SELECT: rdata_q[7:0] <= input_select_q;
        IDX_RESULT_LOW: // [RQ7] [RQ8] [RQ12]
          rdata_q[7:0] <= result_byte(result_q, input_select_q[SEL_LEFT_ADJUST], 1'b0);
        IDX_RESULT_HIGH: // [RQ7] [RQ8] [RQ12]
          rdata_q[7:0] <= result_byte(result_q, input_select_q[SEL_LEFT_ADJUST], 1'b1);
        IDX_IRQ_STATUS: rdata_q[STAT_DONE] <= done_flag_q;
        IDX_IRQ_MASK: rdata_q[STAT_DONE] <= irq_mask_q;
        IDX_CONV_STATUS: begin
          rdata_q[CSTAT_BUSY]   <= conv_busy;
          rdata_q[CSTAT_LOCKED] <= locked_q;
        end
        default: rdata_q[7:0] <= 8'h00;
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : amrf_top

`default_nettype wire

// *** verification/amrf_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module amrf_props
  import amrf_pkg::*;
(
  input wire logic            clk_sys,
  input wire logic            rst_n,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic            conv_start,
  input wire logic            core_done,
  input wire amrf_select_type work_select,
  input wire logic            conv_busy
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  chk_start_busy: assert property (!conv_busy && conv_start |=> conv_busy)
    else $error("start did not raise busy");
  chk_sel_frozen: assert property (conv_busy ##1 conv_busy |-> $stable(work_select))
    else $error("selection moved during conversion");
  chk_busy_holds: assert property (conv_busy && !core_done |=> conv_busy)
    else $error("busy dropped without completion");
  chk_done_idle: assert property (conv_busy && core_done |=> !conv_busy)
    else $error("busy stayed after completion");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
                                s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_rd_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule : amrf_props

bind amrf_top amrf_props chk_u (.clk_sys, .rst_n, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready,
  .conv_start, .core_done, .work_select, .conv_busy);
`default_nettype wire

// *** verification/amrf_core_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module amrf_core_model
  import amrf_pkg::*;
(
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic            conv_busy,
  input  wire amrf_select_type work_select,
  input  wire logic [9:0]      value,
  input  wire logic [3:0]      wait_cycles,
  output logic                 core_done,
  output logic [9:0]           core_code
);
  logic [3:0] cnt_q;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) cnt_q <= 4'h0;
    else if (!conv_busy) cnt_q <= 4'h0;
    else cnt_q <= cnt_q + 4'h1;
  end

  assign core_done = conv_busy && cnt_q == wait_cycles;
  // code only valid with done, scrambled otherwise
  assign core_code = !core_done ? {cnt_q, ~cnt_q, 2'h1} :
                     work_select.channel.differential ? value ^ 10'h200 : value;
endmodule : amrf_core_model
`default_nettype wire

// *** verification/adc_mux_result_format_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module adc_mux_result_format_tb;
  import amrf_pkg::*;
  localparam logic [11:0] A_LO  = {IDX_RESULT_LOW, 2'h0};
  localparam logic [11:0] A_HI  = {IDX_RESULT_HIGH, 2'h0};
  localparam logic [11:0] A_SEL = {IDX_INPUT_SELECT, 2'h0};
  localparam logic [11:0] A_IST = {IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] A_IMK = {IDX_IRQ_MASK, 2'h0};
  localparam logic [11:0] A_CST = {IDX_CONV_STATUS, 2'h0};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, conv_start = 1'b0;
  logic [9:0] value = 10'h000;
  logic [3:0] wait_cycles = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic conv_busy, irq, core_done;
  logic [9:0] core_code;
  amrf_select_type work_select;
  int num_errors = 0;
  int samples_checked = 0;

  always #20 clk_sys = ~clk_sys;

  amrf_top dut_u (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .conv_start, .core_done, .core_code,
    .work_select, .conv_busy, .irq);

  amrf_core_model core_u (.clk_sys, .rst_n, .conv_busy, .work_select, .value,
    .wait_cycles, .core_done, .core_code);

  // ****************************************
  // bus and check tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er = RESP_OKAY);
    logic aw_t, w_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_t && w_t)) begin
      @(posedge clk_sys);
      if (s_axi_awready && !aw_t) begin
        aw_t = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready && !w_t) begin
        w_t = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er = RESP_OKAY);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, {24'h000000, e});
    chk("rresp", s_axi_rresp, er);
  endtask : rd

  task automatic start(input logic [9:0] v, input logic [3:0] w);
    value <= v;
    wait_cycles <= w;
    conv_start <= 1'b1;
    @(posedge clk_sys);
    conv_start <= 1'b0;
  endtask : start

  task automatic finish;
    do @(posedge clk_sys); while (conv_busy);
  endtask : finish

  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude

  initial begin : watchdog
    repeat (20000) @(posedge clk_sys);
    num_errors++;
    conclude();
  end

  // ****************************************
  // test sequence
  // ****************************************
  initial begin : main
    logic [4:0] c;
    logic [1:0] r;
    logic [7:0] pr;
    amrf_chan_type ch;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(A_SEL, 8'h00);
    rd(A_LO, 8'h00);
    rd(A_HI, 8'h00);
    rd(A_IMK, 8'h00);
    rd(12'h000, 8'h00, RESP_SLVERR);
    wr(12'h000, 8'h5A, RESP_SLVERR);
    wr(A_CST, 8'hFF);
    rd(A_CST, 8'h00);
    for (int i = 0; i < 32; i++) begin
      c = i[4:0];
      r = (c[4:3] == 2'b01) ? 2'b11 : c[1:0];
      wr(A_SEL, {r, 1'b0, c});
      @(posedge clk_sys);
      ch = work_select.channel;
      pr = c < 16 ? {1'b0, c[2], c[0], 1'b0, c[2], 1'b0, (c[1] ? 2'b10 : 2'b01)} :
                    {c[2:0], 1'b0, c[3], ~c[3], 2'b00};
      chk("ref", work_select.reference, r);
      chk("diff", ch.differential, c > 7 && c < 30);
      chk("bandgap", ch.bandgap, c == 30);
      chk("ground", ch.ground, c == 31);
      if (c < 8) chk("pos", ch.positive, c[2:0]);
      else if (c < 30) chk("pair", {ch.positive, ch.negative, ch.gain}, pr);
    end
    wr(A_IMK, 8'h01);
    wr(A_SEL, 8'hED);
    start(10'h270, 4'hC);
    wr(A_SEL, 8'h0D);
    chk("frozen", work_select.reference, REF_INTERNAL_2V56);
    rd(A_CST, 8'h01);
    finish();
    @(posedge clk_sys);
    chk("taken", work_select.reference, REF_EXTERNAL_PIN);
    chk("irq", irq, 1'b1);
    rd(A_LO, 8'h70);
    rd(A_HI, 8'h02);
    start(10'h1FF, 4'hF);
    wr(A_SEL, 8'h2D);
    rd(A_LO, 8'h00);
    rd(A_HI, 8'h9C);
    finish();
    rd(A_LO, 8'hC0);
    rd(A_HI, 8'h7F);
    wr(A_IST, 8'h01);
    chk("irq", irq, 1'b0);
    rd(A_IST, 8'h00);
    wr(A_IMK, 8'h00);
    wr(A_SEL, 8'h40);
    start(10'h3FF, 4'h0);
    finish();
    chk("irq", irq, 1'b0);
    rd(A_IST, 8'h01);
    rd(A_LO, 8'hFF);
    rd(A_HI, 8'h03);
    start(10'h155, 4'h2);
    finish();
    rd(A_LO, 8'h55);
    rd(A_CST, 8'h02);
    start(10'h000, 4'h2);
    finish();
    rd(A_HI, 8'h01);
    start(10'h000, 4'h1);
    finish();
    rd(A_LO, 8'h00);
    rd(A_HI, 8'h00);
    conclude();
  end
endmodule : adc_mux_result_format_tb
`default_nettype wire
